// File: rtl/nmed_map.sv
`timescale 1ns/100ps
/*
  rename map: architectural to physical register table with registered read.
  assumes one write and two reads per cycle on mclk.
*/
module nmed_map (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic [nmed_pkg::ARCH_W-1:0] rd_a_idx,
  input  wire logic [nmed_pkg::ARCH_W-1:0] rd_b_idx,
  output logic      [nmed_pkg::PHYS_W-1:0] rd_a_q,
  output logic      [nmed_pkg::PHYS_W-1:0] rd_b_q,
  input  wire logic                        wr_en,
  input  wire logic [nmed_pkg::ARCH_W-1:0] wr_idx,
  input  wire logic [nmed_pkg::PHYS_W-1:0] wr_phys
);
  import nmed_pkg::*;
  logic [PHYS_W-1:0] tab_q [NARCH];  // mapping table

  // table write, reset maps each register to itself
  always_ff @(posedge mclk) begin
    for (int i = 0; i < NARCH; i++) begin
      if (rst) begin
        tab_q[i] <= PHYS_W'(i);
      end else if (wr_en && wr_idx == ARCH_W'(i)) begin
        tab_q[i] <= wr_phys;
      end
    end
  end

  // registered reads
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_a_q <= '0;
      rd_b_q <= '0;
    end else begin
      rd_a_q <= tab_q[rd_a_idx];
      rd_b_q <= tab_q[rd_b_idx];
    end
  end
endmodule : nmed_map

// File: rtl/nmed_pkg.sv
/*
  constants and types for the no-op and move elimination stage.
  assumes a decoder that hands over one instruction per cycle with its bytes,
  length and register fields already extracted.
*/
package nmed_pkg;
  // widths
  localparam int ARCH_W   = 5;            // architectural register index width
  localparam int PHYS_W   = 7;            // physical register index width
  localparam int NARCH    = 32;           // architectural registers tracked
  localparam int LEN_W    = 4;            // instruction length field
  localparam int ELIM_W   = 3;            // elimination credit counter width
  localparam logic [ELIM_W-1:0] ELIM_SLOTS = 3'h4;  // tracking entries
  // opcode bytes
  localparam logic [7:0] OP_REGISTER_EXCHANGE_OP_ACC = 8'h90;  // one-byte exchange with accumulator
  localparam logic [7:0] OP_OPSIZE   = 8'h66;  // operand size prefix
  localparam logic [7:0] OP_LEA      = 8'h8D;  // load effective address
  localparam logic [7:0] OP_ESC      = 8'h0F;  // two-byte escape
  localparam logic [7:0] OP_NOPM     = 8'h1F;  // memory-operand no-op
  // mod field values
  localparam logic [1:0] MOD_D8  = 2'h1;   // 8-bit displacement
  localparam logic [1:0] MOD_D32 = 2'h2;   // 32-bit displacement
  localparam logic [2:0] RM_SIB  = 3'h4;   // sib follows
  // move classes from the decoder
  typedef enum logic [3:0] {
    NMED_MV_NONE   = 4'h0,
    NMED_MV_R8     = 4'h1,
    NMED_MV_R16    = 4'h2,
    NMED_MV_R32    = 4'h3,
    NMED_MV_R64    = 4'h4,
    NMED_MV_VPS    = 4'h5,  // packed single, aligned or unaligned
    NMED_MV_VPD    = 4'h6,  // packed double
    NMED_MV_VINT   = 4'h7,  // packed integer
    NMED_MV_ZX32   = 4'h8,
    NMED_MV_ZX64   = 4'h9,
    NMED_MV_SX     = 4'hA
  } nmed_mv_t;
  // vector data domain
  typedef enum logic [1:0] {
    NMED_DOM_INT = 2'h0,
    NMED_DOM_FP  = 2'h1
  } nmed_dom_t;
  localparam logic [1:0] BYPASS_CYC = 2'h1;   // domain crossing penalty
  // output stage state
  typedef enum logic [1:0] {
    NMED_ST_IDLE = 2'b00,
    NMED_ST_PASS = 2'b01,
    NMED_ST_HOLD = 2'b11
  } nmed_st_t;
endpackage : nmed_pkg

// File: rtl/nmed_top.sv
`timescale 1ns/100ps
/*
  padding no-op recognition and move elimination between decode and the
  reservation station. assumes the decoder presents one instruction a cycle
  with valid/ready, raw leading bytes, length, register fields and move class;
  the scheduler frees elimination entries with a one-cycle pulse.
*/
// Summary of operation
// (RULE_01) decode one to nine byte padding forms
// (RULE_02) eight or thirty-two bit displacement both qualify
// (RULE_03) padding changes nothing except instruction pointer
// (RULE_04) one-byte form drops accumulator dependence
// (RULE_05) multi-byte padding keeps real register dependencies
// (RULE_06) every padding form still issues a micro-op
// (RULE_07) qualifying moves complete in front end
// (RULE_08) full width general and vector moves eligible
// (RULE_09) zero-extend eligible only from low-byte source
// (RULE_10) narrow, sign-extend, high-byte moves execute normally
// (RULE_11) finite tracking entries limit elimination rate
// (RULE_12) integer/float vector domain crossing adds delay
// (RULE_13) aligned single and double moves behave alike
// (RULE_14) eliminated move remaps destination, issues nothing
module nmed_top (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        dec_valid,      // instruction offered
  output logic                             dec_ready,      // stage accepts
  input  wire logic [7:0]                  dec_b0,         // leading bytes
  input  wire logic [7:0]                  dec_b1,
  input  wire logic [7:0]                  dec_b2,
  input  wire logic [7:0]                  dec_b3,
  input  wire logic [nmed_pkg::LEN_W-1:0]  dec_len,        // length in bytes
  input  wire logic [31:0]                 dec_ip,         // instruction pointer
  input  wire nmed_pkg::nmed_mv_t          dec_mv,         // move class
  input  wire logic                        dec_src_hi,     // source is high byte register
  input  wire logic                        dec_is_vec,     // vector operation
  input  wire nmed_pkg::nmed_dom_t         dec_dom,        // vector data domain
  input  wire logic [nmed_pkg::ARCH_W-1:0] dec_src,
  input  wire logic [nmed_pkg::ARCH_W-1:0] dec_dst,
  input  wire logic                        elim_free,      // one entry released
  input  wire logic                        rs_ready,       // station accepts
  output logic                             rs_valid_q,     // micro-op to station
  output logic [nmed_pkg::PHYS_W-1:0]      rs_src_phys_q,
  output logic                             rs_src_dep_q,   // wait on source
  output logic [nmed_pkg::ARCH_W-1:0]      rs_dst_q,
  output logic                             rs_is_nop_q,    // no architectural effect
  output logic [1:0]                       rs_bypass_q,    // extra cycles
  output logic [31:0]                      next_ip_q,      // pointer after instruction
  output logic                             elim_done_q,    // move retired in front end
  output logic [nmed_pkg::ARCH_W-1:0]      elim_dst_q,
  output logic [nmed_pkg::PHYS_W-1:0]      elim_phys_q
);
  import nmed_pkg::*;

  // length of a memory operand padding form from modrm
  function automatic logic [LEN_W-1:0] mem_len(input logic [7:0] modrm, input logic [LEN_W-1:0] base);
    logic [LEN_W-1:0] l;
    l = base + ((modrm[7:6] == MOD_D32) ? LEN_W'(4) : LEN_W'(1));
    if (modrm[2:0] == RM_SIB) begin
      l = l + LEN_W'(1);
    end
    return l;
  endfunction : mem_len

  // true when modrm has a displacement of either size
  function automatic logic has_disp(input logic [7:0] modrm);
    return (modrm[7:6] == MOD_D8) || (modrm[7:6] == MOD_D32);
  endfunction : has_disp

  // pipeline holding registers
  nmed_st_t          st_q, st_d;             // output stage state
  logic [ELIM_W-1:0] credit_q, credit_d;     // free tracking entries
  nmed_dom_t         dom_q [NARCH];          // last vector producing domain per register
  logic              hold_nop1_q;            // captured flags for map read cycle
  logic              hold_pad_q;
  logic              hold_elim_q;
  logic [1:0]        hold_byp_q;
  logic [ARCH_W-1:0] hold_dst_q;
  logic [31:0]       hold_nip_q;
  logic [PHYS_W-1:0] hold_src_q;             // source physical kept while output stalls
  logic [PHYS_W-1:0] map_src;                // map read data
  logic [PHYS_W-1:0] map_dst;

  // padding recognition
  wire nop1     = dec_b0 == OP_REGISTER_EXCHANGE_OP_ACC && dec_len == LEN_W'(1);                   // [RULE_01] [RULE_04]
  wire nop2     = dec_b0 == OP_OPSIZE && dec_b1 == OP_REGISTER_EXCHANGE_OP_ACC && dec_len == LEN_W'(2);  // [RULE_01]
  wire lea_pad  = dec_b0 == OP_LEA && has_disp(dec_b1) && dec_b1[5:3] == dec_b1[2:0]
                  && dec_b1[2:0] != RM_SIB && dec_len == mem_len(dec_b1, LEN_W'(2)); // [RULE_02]
  wire mem_pad  = dec_b0 == OP_ESC && dec_b1 == OP_NOPM && has_disp(dec_b2)
                  && dec_len == mem_len(dec_b2, LEN_W'(3));                           // [RULE_02]
  wire mem_pad16 = dec_b0 == OP_OPSIZE && dec_b1 == OP_ESC && dec_b2 == OP_NOPM
                  && has_disp(dec_b3) && dec_len == mem_len(dec_b3, LEN_W'(4));       // [RULE_01]
  wire is_pad   = nop1 | nop2 | lea_pad | mem_pad | mem_pad16;

  // move eligibility
  wire mv_full  = dec_mv inside {NMED_MV_R32, NMED_MV_R64, NMED_MV_VPS, NMED_MV_VPD, NMED_MV_VINT};  // [RULE_08] [RULE_13]
  wire mv_zx    = (dec_mv inside {NMED_MV_ZX32, NMED_MV_ZX64}) && !dec_src_hi;      // [RULE_09]
  wire mv_elig  = !is_pad && (mv_full || mv_zx);                                    // [RULE_10]
  wire do_elim  = mv_elig && credit_q != '0;                                        // [RULE_11]

  // domain crossing penalty for vector consumers
  wire [1:0] byp = (dec_is_vec && !do_elim && dom_q[dec_src] != dec_dom) ? BYPASS_CYC : 2'h0;  // [RULE_12]

  wire take     = dec_valid && dec_ready;
  wire out_free = !rs_valid_q || rs_ready;
  // result leaves from pass or from hold once the station slot is free
  wire emit     = (st_q == NMED_ST_PASS || st_q == NMED_ST_HOLD) && out_free;
  // map read port follows the decoder, so a stalled result uses the kept copy
  wire [PHYS_W-1:0] src_pick = (st_q == NMED_ST_HOLD) ? hold_src_q : map_src;

  // stage is ready when nothing waits in the map read cycle and output drains
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      NMED_ST_IDLE: if (take) st_d = NMED_ST_PASS;
      NMED_ST_PASS: if (!take) st_d = out_free ? NMED_ST_IDLE : NMED_ST_HOLD;
      NMED_ST_HOLD: if (out_free) st_d = NMED_ST_IDLE;
      default:      st_d = NMED_ST_IDLE;
    endcase
  end

  // tracking entry credits, release and claim in the same cycle both apply
  always_comb begin
    credit_d = credit_q;
    if (take && do_elim) credit_d = credit_d - ELIM_W'(1);                           // [RULE_11]
    if (elim_free && credit_d != ELIM_SLOTS) credit_d = credit_d + ELIM_W'(1);
  end

  // rename map, eliminated move points destination at source physical
  nmed_map u_map (
    .mclk     (mclk),
    .rst      (rst),
    .rd_a_idx (dec_src),
    .rd_b_idx (dec_dst),
    .rd_a_q   (map_src),
    .rd_b_q   (map_dst),
    .wr_en    (elim_done_q),
    .wr_idx   (elim_dst_q),
    .wr_phys  (elim_phys_q)                                                        // [RULE_14]
  );

  // state and credits
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q     <= NMED_ST_IDLE;
      credit_q <= ELIM_SLOTS;
    end else begin
      st_q     <= st_d;
      credit_q <= credit_d;
    end
  end

  // domain of the last vector writer per register; padding leaves it untouched
  always_ff @(posedge mclk) begin
    for (int i = 0; i < NARCH; i++) begin
      if (rst) begin
        dom_q[i] <= NMED_DOM_INT;
      end else if (take && dec_is_vec && !is_pad && dec_dst == ARCH_W'(i)) begin     // [RULE_03]
        dom_q[i] <= dec_dom;
      end
    end
  end

  // capture decode facts while the map read is in flight
  always_ff @(posedge mclk) begin
    if (rst) begin
      hold_nop1_q <= 1'b0;
      hold_pad_q  <= 1'b0;
      hold_elim_q <= 1'b0;
      hold_byp_q  <= 2'h0;
      hold_dst_q  <= '0;
      hold_nip_q  <= 32'h0;
    end else if (take) begin
      hold_nop1_q <= nop1;
      hold_pad_q  <= is_pad;
      hold_elim_q <= do_elim;
      hold_byp_q  <= byp;
      hold_dst_q  <= dec_dst;
      hold_nip_q  <= dec_ip + 32'(dec_len);                                          // [RULE_03]
    end
  end

  // keep the source mapping once the map read has landed
  always_ff @(posedge mclk) begin
    if (rst) begin
      hold_src_q <= '0;
    end else if (st_q == NMED_ST_PASS) begin
      hold_src_q <= map_src;
    end
  end

  // one instruction in flight; ready waits a full idle cycle so a map
  // write from an eliminated move lands before the next read
  always_ff @(posedge mclk) begin
    if (rst) begin
      dec_ready <= 1'b0;
    end else begin
      dec_ready <= (st_d == NMED_ST_IDLE) && (st_q == NMED_ST_IDLE) && !take;
    end
  end

  // output to the station and the elimination report
  always_ff @(posedge mclk) begin
    if (rst) begin
      rs_valid_q    <= 1'b0;
      rs_src_phys_q <= '0;
      rs_src_dep_q  <= 1'b0;
      rs_dst_q      <= '0;
      rs_is_nop_q   <= 1'b0;
      rs_bypass_q   <= 2'h0;
      next_ip_q     <= 32'h0;
      elim_done_q   <= 1'b0;
      elim_dst_q    <= '0;
      elim_phys_q   <= '0;
    end else begin
      elim_done_q <= 1'b0;
      if (rs_valid_q && rs_ready) begin
        rs_valid_q <= 1'b0;
      end
      if (emit) begin
        next_ip_q <= hold_nip_q;                                                     // [RULE_03]
        if (hold_elim_q) begin
          elim_done_q <= 1'b1;                                                       // [RULE_07] [RULE_14]
          elim_dst_q  <= hold_dst_q;
          elim_phys_q <= src_pick;
        end else begin
          rs_valid_q    <= 1'b1;                                                     // [RULE_06]
          rs_src_phys_q <= src_pick;
          rs_src_dep_q  <= !hold_nop1_q;                                             // [RULE_04] [RULE_05]
          rs_dst_q      <= hold_dst_q;
          rs_is_nop_q   <= hold_pad_q;                                               // [RULE_03]
          rs_bypass_q   <= hold_byp_q;                                               // [RULE_12]
        end
      end
    end
  end

  wire unused_dst = ^map_dst;  // second read port kept for destination lookups
endmodule : nmed_top

// File: test/nmed_assertions.sv
`timescale 1ns/100ps
/*
  port-level checker for the no-op and move elimination stage.
  assumes it is bound to nmed_top and sees only its ports.
*/
module nmed_assertions (
  input wire logic                        mclk, rst, dec_valid, dec_ready, dec_src_hi, elim_free, rs_ready,
  input wire logic                        rs_valid_q, rs_src_dep_q, rs_is_nop_q, elim_done_q,
  input wire logic [7:0]                  dec_b0, dec_b1,
  input wire logic [nmed_pkg::LEN_W-1:0]  dec_len,
  input wire logic [31:0]                 dec_ip, next_ip_q,
  input wire nmed_pkg::nmed_mv_t          dec_mv,
  input wire logic [nmed_pkg::ARCH_W-1:0] dec_dst, rs_dst_q, elim_dst_q
);
  import nmed_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic take;                // instruction accepted this edge
  logic [ELIM_W-1:0] used_q; // entries claimed and not yet released
  assign take = dec_valid && dec_ready;
  // shadow count of tracking entries in use
  always_ff @(posedge mclk) begin
    if (rst) used_q <= '0;
    else used_q <= used_q + {2'h0, elim_done_q} - {2'h0, elim_free};
  end
  AST_HOLD: assert property (rs_valid_q && !rs_ready |=> rs_valid_q && $stable(rs_dst_q))
    else $error("station output dropped before accept");
  AST_GAP: assert property (take |=> !dec_ready [*2])
    else $error("second instruction taken too soon");
  AST_IP: assert property (take |-> ##2 next_ip_q == $past(dec_ip, 2) + 32'($past(dec_len, 2)))
    else $error("pointer after instruction wrong");
  AST_ONE: assert property (take && dec_b0 == OP_REGISTER_EXCHANGE_OP_ACC && dec_len == 4'h1 |-> ##2 rs_valid_q && rs_is_nop_q && !rs_src_dep_q)
    else $error("one byte padding kept a dependence");
  AST_MULTI: assert property (take && dec_b0 == OP_ESC && dec_b1 == OP_NOPM |-> ##2 rs_valid_q && rs_is_nop_q && rs_src_dep_q)
    else $error("multi byte padding lost its dependence");
  AST_NARROW: assert property (take && (dec_mv inside {NMED_MV_R8, NMED_MV_R16, NMED_MV_SX} || (dec_mv inside {NMED_MV_ZX32, NMED_MV_ZX64} && dec_src_hi)) |-> ##2 rs_valid_q && !elim_done_q)
    else $error("ineligible move eliminated");
  AST_WIDE: assert property (take && dec_mv inside {NMED_MV_R32, NMED_MV_R64, NMED_MV_VPS, NMED_MV_VPD, NMED_MV_VINT} && used_q < ELIM_SLOTS |-> ##2 elim_done_q)
    else $error("eligible move not eliminated");
  AST_NOISSUE: assert property (elim_done_q |-> !rs_valid_q && elim_dst_q == $past(dec_dst, 2))
    else $error("eliminated move issued or wrong destination");
  AST_PULSE: assert property (elim_done_q |=> !elim_done_q)
    else $error("elimination done longer than one cycle");
  AST_CREDIT: assert property (elim_done_q |-> used_q < ELIM_SLOTS)
    else $error("elimination beyond tracking entries");
endmodule : nmed_assertions
bind nmed_top nmed_assertions chk_u (.mclk(mclk), .rst(rst), .dec_valid(dec_valid), .dec_ready(dec_ready),
  .dec_src_hi(dec_src_hi), .elim_free(elim_free), .rs_ready(rs_ready), .rs_valid_q(rs_valid_q),
  .rs_src_dep_q(rs_src_dep_q), .rs_is_nop_q(rs_is_nop_q), .elim_done_q(elim_done_q), .dec_b0(dec_b0),
  .dec_b1(dec_b1), .dec_len(dec_len), .dec_ip(dec_ip), .next_ip_q(next_ip_q), .dec_mv(dec_mv),
  .dec_dst(dec_dst), .rs_dst_q(rs_dst_q), .elim_dst_q(elim_dst_q));

// File: test/nmed_sched_model.sv
`timescale 1ns/100ps
/*
  scheduler model: accepts micro-ops after a set stall and releases
  elimination entries one at a time while release is enabled.
*/
module nmed_sched_model (
  input  wire logic       mclk, rst, rs_valid_q, elim_done_q, auto_free,
  input  wire logic [3:0] hold,      // stall cycles before accept
  output logic            rs_ready,  // one-cycle accept
  output logic            elim_free  // one entry released
);
  logic [3:0] cnt_q;   // cycles waited on current micro-op
  logic [2:0] owed_q;  // entries held by the scheduler
  logic       rel;     // release this cycle
  assign rel = auto_free && owed_q != 3'h0 && !elim_free;
  // accept after the stall, release entries spaced out
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= 4'h0; owed_q <= 3'h0; rs_ready <= 1'b0; elim_free <= 1'b0;
    end else begin
      rs_ready <= rs_valid_q && !rs_ready && cnt_q == hold;
      cnt_q <= (rs_valid_q && !rs_ready) ? cnt_q + 4'h1 : 4'h0;
      elim_free <= rel;
      owed_q <= owed_q + {2'h0, elim_done_q} - {2'h0, rel};
    end
  end
endmodule : nmed_sched_model

// File: test/nmed_top_tb.sv
`timescale 1ns/100ps
/*
  testbench for the no-op and move elimination stage.
  assumes the scheduler model on the station side; one instruction in flight.
*/
module nmed_top_tb;
  import nmed_pkg::*;
  logic mclk = 0, rst = 1, dec_valid = 0, dec_src_hi = 0, dec_is_vec = 0, auto_free = 1;
  logic [7:0] dec_b0 = 0, dec_b1 = 0, dec_b2 = 0, dec_b3 = 0;
  logic [LEN_W-1:0] dec_len = 0;
  logic [3:0] hold = 0;
  logic [31:0] dec_ip = 0, ip_s = 0;
  nmed_mv_t dec_mv = NMED_MV_NONE;
  nmed_dom_t dec_dom = NMED_DOM_INT;
  logic [ARCH_W-1:0] dec_src = 0, dec_dst = 0, dst_s;
  wire logic dec_ready, elim_free, rs_ready, rs_valid_q, rs_src_dep_q, rs_is_nop_q, elim_done_q;
  wire logic [PHYS_W-1:0] rs_src_phys_q, elim_phys_q;
  wire logic [ARCH_W-1:0] rs_dst_q, elim_dst_q;
  wire logic [1:0] rs_bypass_q;
  wire logic [31:0] next_ip_q;
  int n_fail = 0, num_checks = 0, wait_n;
  logic got_rs, got_el, dep_s, nop_s;
  logic [1:0] byp_s;
  logic [PHYS_W-1:0] phys_s;
  always #25 mclk = ~mclk;
  nmed_top dut_u (.mclk(mclk), .rst(rst), .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_b0(dec_b0),
    .dec_b1(dec_b1), .dec_b2(dec_b2), .dec_b3(dec_b3), .dec_len(dec_len), .dec_ip(dec_ip), .dec_mv(dec_mv),
    .dec_src_hi(dec_src_hi), .dec_is_vec(dec_is_vec), .dec_dom(dec_dom), .dec_src(dec_src), .dec_dst(dec_dst),
    .elim_free(elim_free), .rs_ready(rs_ready), .rs_valid_q(rs_valid_q), .rs_src_phys_q(rs_src_phys_q),
    .rs_src_dep_q(rs_src_dep_q), .rs_dst_q(rs_dst_q), .rs_is_nop_q(rs_is_nop_q), .rs_bypass_q(rs_bypass_q),
    .next_ip_q(next_ip_q), .elim_done_q(elim_done_q), .elim_dst_q(elim_dst_q), .elim_phys_q(elim_phys_q));
  nmed_sched_model sched_u (.mclk(mclk), .rst(rst), .rs_valid_q(rs_valid_q), .elim_done_q(elim_done_q),
    .auto_free(auto_free), .hold(hold), .rs_ready(rs_ready), .elim_free(elim_free));
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  // offer one instruction, wait for its answer and the station accept
  task automatic send(input logic [31:0] b, input logic [3:0] len, input nmed_mv_t mv, input logic hi,
                      input logic [4:0] dst);
    int k;
    ip_s = ip_s + 32'h10;
    @(posedge mclk);
    dec_valid <= 1'b1; {dec_b0, dec_b1, dec_b2, dec_b3} <= b; dec_len <= len; dec_mv <= mv;
    dec_src_hi <= hi; dec_dst <= dst; dec_src <= dst + 5'h3; dec_ip <= ip_s;
    dec_is_vec <= mv inside {NMED_MV_VPS, NMED_MV_VPD, NMED_MV_VINT};
    dec_dom <= (mv == NMED_MV_VINT) ? NMED_DOM_INT : NMED_DOM_FP;
    #1;
    for (k = 0; k < 20 && !dec_ready; k++) begin
      @(posedge mclk); #1;
    end
    @(posedge mclk);
    dec_valid <= 1'b0;
    got_rs = 0; got_el = 0;
    for (k = 0; k < 20 && !got_rs && !got_el; k++) begin
      @(posedge mclk); #1;
      got_rs = rs_valid_q; got_el = elim_done_q;
    end
    dep_s = rs_src_dep_q; nop_s = rs_is_nop_q; dst_s = got_el ? elim_dst_q : rs_dst_q;
    byp_s = rs_bypass_q; phys_s = got_el ? elim_phys_q : rs_src_phys_q;
    chk("next_ip", next_ip_q, ip_s + 32'(len));
    for (k = 0; k < 30 && rs_valid_q; k++) begin
      @(posedge mclk); #1;
    end
    wait_n = k;
  endtask : send
  // every padding length, both displacement widths
  task automatic t_pad;
    logic [31:0] pb [9] = '{32'h90000000, 32'h66900000, 32'h8D400000, 32'h0F1F4000, 32'h0F1F4400,
                            32'h8D800000, 32'h0F1F8000, 32'h0F1F8400, 32'h660F1F84};
    for (int i = 0; i < 9; i++) begin
      send(pb[i], 4'(i + 1), NMED_MV_NONE, 1'b0, 5'h2);
      chk("pad_issued", got_rs, 1);
      chk("pad_nop", nop_s, 1);
      chk("pad_dep", dep_s, i != 0);
      chk("pad_byp", byp_s, 0);
    end
  endtask : t_pad
  // every move class, low and high byte sources
  task automatic t_moves;
    nmed_mv_t mv [12] = '{NMED_MV_R8, NMED_MV_R16, NMED_MV_R32, NMED_MV_R64, NMED_MV_VPS, NMED_MV_VPD,
                          NMED_MV_VINT, NMED_MV_ZX32, NMED_MV_ZX64, NMED_MV_ZX32, NMED_MV_ZX64, NMED_MV_SX};
    logic [11:0] hi = 12'h600;  // high byte source
    logic [11:0] el = 12'h1FC;  // expected eliminated
    for (int i = 0; i < 12; i++) begin
      send(32'h0, 4'h3, mv[i], hi[i], 5'(i + 4));
      repeat (4) @(posedge mclk);
      chk("move_elim", got_el, el[i]);
      chk("move_exec", got_rs, !el[i]);
      chk("move_dst", dst_s, 5'(i + 4));
    end
  endtask : t_moves
  // dense moves with no entries returned
  task automatic t_credit;
    auto_free <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      send(32'h0, 4'h2, (i < 4) ? NMED_MV_R64 : NMED_MV_VPS, 1'b0, 5'h9);
      chk("credit_elim", got_el, i < 4);
      if (i == 0) chk("remap_phys", phys_s, 15);
      if (i == 4) chk("domain_byp", byp_s, 1);
    end
    auto_free <= 1'b1;
    repeat (12) @(posedge mclk);
    send(32'h0, 4'h2, NMED_MV_R32, 1'b0, 5'hA);
    chk("credit_back", got_el, 1);
  endtask : t_credit
  // station stalls a one-byte padding op
  task automatic t_stall;
    hold <= 4'h5;
    send(32'h90000000, 4'h1, NMED_MV_NONE, 1'b0, 5'h1);
    chk("stall_held", wait_n > 5, 1);
    hold <= 4'h0;
  endtask : t_stall
  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_pad;
    t_moves;
    t_credit;
    t_stall;
    repeat (3) @(posedge mclk);
    close_out;
  end
  // watchdog
  initial begin
    #200000;
    n_fail++;
    close_out;
  end
endmodule : nmed_top_tb
